// [core/tci_capture_prescaler.sv]
`include "tci_defines.svh"
module tci_capture_prescaler
  import tci_pkg::*;
#(
  parameter int CNT_W = 3
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic enable,
  input wire logic [1:0] psc,
  input wire logic evt_in,
  output logic evt_out
);

  generate
    if (CNT_W < 3) begin : g_bad_width
      $error("prescaler counter must hold at least 3 bits");
    end
  endgenerate

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic out;
  } tci_psc_state_t;

  tci_psc_state_t st_r;
  tci_psc_state_t st_nxt;
  logic [CNT_W-1:0] mask;

  assign mask = CNT_W'((4'h1 << psc) - 4'h1);

  always_comb begin
    st_nxt = st_r;
    st_nxt.out = 1'b0;
    if (!enable) begin
      st_nxt.cnt = '0;
    end else if (evt_in) begin
      if ((st_r.cnt & mask) == mask) begin
        st_nxt.out = 1'b1;
        st_nxt.cnt = '0;
      end else begin
        st_nxt.cnt = st_r.cnt + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign evt_out = st_r.out;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  psc_clear_off_a: assert property (!enable |=> st_r.cnt == '0)
    else $error("prescaler count not cleared while channel disabled");
  psc_pass_all_a: assert property (enable && psc == 2'h0 && evt_in |=> evt_out)
    else $error("undivided event did not pass");
  psc_every_eighth_a: assert property (evt_out && $past(psc) == 2'h3 |-> $past(st_r.cnt) == CNT_W'(7))
    else $error("divide by eight passed early");
  psc_cause_a: assert property (evt_out |-> $past(evt_in) && $past(enable))
    else $error("event out without event in");

endmodule : tci_capture_prescaler

// [core/tci_digital_filter.sv]
`include "tci_defines.svh"
module tci_digital_filter
  import tci_pkg::*;
#(
  parameter int DIV_W = 6,
  parameter int CNT_W = 4
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [3:0] flt_code,
  input wire logic dts_en,
  input wire logic clkin_en,
  input wire logic din,
  output logic dout
);

  generate
    if (DIV_W < 6 || CNT_W < 4) begin : g_bad_width
      $error("filter counters too narrow for the filter table");
    end
  endgenerate

  typedef struct packed {
    logic [DIV_W-1:0] div_cnt;
    logic [CNT_W-1:0] cnt;
    logic out;
  } tci_flt_state_t;

  tci_flt_state_t st_r;
  tci_flt_state_t st_nxt;
  logic tick;
  logic sample_en;
  logic [DIV_W-1:0] div_last;
  logic [CNT_W-1:0] n_last;

  assign tick = (tci_filter_src(flt_code) == TCI_SRC_CLKIN) ? clkin_en : dts_en;
  assign div_last = DIV_W'(tci_filter_div(flt_code) - 6'h01);
  assign n_last = CNT_W'(tci_filter_n(flt_code) - 4'h1);
  assign sample_en = tick && (st_r.div_cnt >= div_last);

  always_comb begin
    st_nxt = st_r;
    if (tick) begin
      st_nxt.div_cnt = sample_en ? '0 : st_r.div_cnt + DIV_W'(1);
    end
    if (sample_en) begin
      if (din == st_r.out) begin
        st_nxt.cnt = '0;
      end else if (st_r.cnt >= n_last) begin
        st_nxt.out = din;
        st_nxt.cnt = '0;
      end else begin
        st_nxt.cnt = st_r.cnt + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign dout = st_r.out;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  flt_n_agree_a: assert property ($changed(dout) |-> $past(sample_en) && $past(st_r.cnt) >= $past(n_last))
    else $error("filter output moved before enough agreeing samples");
  flt_bypass_a: assert property (flt_code == 4'h0 && dts_en |-> sample_en)
    else $error("unfiltered code does not sample every dead-time tick");
  flt_clkin_a: assert property (flt_code inside {4'h1, 4'h2, 4'h3} |-> sample_en == clkin_en)
    else $error("sampling not at timer input clock");
  flt_div32_a: assert property (sample_en && $stable(flt_code) && flt_code >= 4'hd |-> st_r.div_cnt == DIV_W'(31))
    else $error("divide by 32 sampling off");

endmodule : tci_digital_filter

// [core/tci_top.sv]
// Summary of operation
// - prescale capture events by 1, 2, 4, 8
// - clear prescaler count while channel disabled
// - direction picks output, own, neighbour, trigger
// - direction writable only while channel disabled
// - output follows after N agreeing samples
// - filter codes 0 to 4 decode
// - filter codes 5 to 15 decode
//
// Design decision made here: the AHB-Lite register port.
`include "tci_defines.svh"
module tci_top
  import tci_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic chan1_capture_compare_enable,
  input wire logic chan1_timer_input,
  input wire logic chan0_timer_input,
  input wire logic trigger_ctrl_edge_signal,
  input wire logic dead_time_clock_en,
  input wire logic timer_input_clock_en,
  output logic [1:0] chan1_direction_select,
  output logic chan1_input_filtered,
  output logic chan1_capture_event
);

  typedef struct packed {
    logic [1:0] psc;
    tci_dir_t dir;
    logic [3:0] flt;
    logic ph_hit;
    logic ph_wr;
    logic [31:0] rdata;
    logic sel_prev;
    logic wr_seen;
  } tci_top_state_t;

  tci_top_state_t st_r;
  tci_top_state_t st_nxt;

  logic addr_acc;
  logic addr_hit;
  logic wr_now;
  logic filt_level;
  logic sel_level;
  logic evt_raw;
  logic [31:0] cfg_word_nxt;
  logic rd_hit;

  // config word as software reads it back
  function automatic logic [31:0] tci_cfg_word(input logic [1:0] psc, input logic [1:0] dir,
    input logic [3:0] flt);
    logic [31:0] w;
    w = '0;
    w[`TCI_PSC_MSB:`TCI_PSC_LSB] = psc;
    w[`TCI_DIR_MSB:`TCI_DIR_LSB] = dir;
    w[`TCI_FLT_MSB:`TCI_FLT_LSB] = flt;
    return w;
  endfunction : tci_cfg_word

  // single-word slave, always ready, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st_r.rdata;

  assign addr_acc = hsel && hready && htrans[1];
  assign addr_hit = (haddr == `TCI_CFG_OFFSET);
  assign wr_now = st_r.ph_hit && st_r.ph_wr;
  assign rd_hit = addr_acc && !hwrite && addr_hit;

  tci_digital_filter #(
    .DIV_W(6),
    .CNT_W(4)
  ) u_filter (
    .hclk(hclk),
    .hresetn(hresetn),
    .flt_code(st_r.flt),
    .dts_en(dead_time_clock_en),
    .clkin_en(timer_input_clock_en),
    .din(chan1_timer_input),
    .dout(filt_level)
  );

  // source selection for the capture path
  always_comb begin
    sel_level = 1'b0;
    unique case (st_r.dir)
      TCI_DIR_OUTPUT: sel_level = 1'b0;
      TCI_DIR_OWN: sel_level = filt_level;
      TCI_DIR_NEIGHBOUR: sel_level = chan0_timer_input;
      TCI_DIR_TRIGGER: sel_level = trigger_ctrl_edge_signal;
    endcase
  end

  // rising edge of the selected level is the active event
  assign evt_raw = sel_level && !st_r.sel_prev && (st_r.dir != TCI_DIR_OUTPUT) && chan1_capture_compare_enable;

  tci_capture_prescaler #(
    .CNT_W(3)
  ) u_prescaler (
    .hclk(hclk),
    .hresetn(hresetn),
    .enable(chan1_capture_compare_enable),
    .psc(st_r.psc),
    .evt_in(evt_raw),
    .evt_out(chan1_capture_event)
  );

  always_comb begin
    st_nxt = st_r;
    st_nxt.sel_prev = sel_level;
    if (wr_now) begin
      st_nxt.wr_seen = 1'b1;
      st_nxt.psc = hwdata[`TCI_PSC_MSB:`TCI_PSC_LSB];
      st_nxt.flt = hwdata[`TCI_FLT_MSB:`TCI_FLT_LSB];
      if (!chan1_capture_compare_enable) begin
        st_nxt.dir = tci_dir_t'(hwdata[`TCI_DIR_MSB:`TCI_DIR_LSB]);
      end
    end
    st_nxt.ph_hit = addr_acc && addr_hit;
    st_nxt.ph_wr = addr_acc && hwrite;
    cfg_word_nxt = tci_cfg_word(st_nxt.psc, st_nxt.dir, st_nxt.flt);
    // forwarded so a read right after a write sees the new value
    if (rd_hit) begin
      st_nxt.rdata = cfg_word_nxt;
    end else if (addr_acc) begin
      st_nxt.rdata = `TCI_RDATA_RST;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r.psc <= `TCI_PSC_RST;
      st_r.dir <= tci_dir_t'(`TCI_DIR_RST);
      st_r.flt <= `TCI_FLT_RST;
      st_r.ph_hit <= 1'b0;
      st_r.ph_wr <= 1'b0;
      st_r.rdata <= `TCI_RDATA_RST;
      st_r.sel_prev <= 1'b0;
      st_r.wr_seen <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign chan1_direction_select = st_r.dir;
  assign chan1_input_filtered = filt_level;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence cfg_write_s;
    wr_now && !chan1_capture_compare_enable;
  endsequence

  sequence locked_write_s;
    wr_now && chan1_capture_compare_enable;
  endsequence

  sequence neighbour_rise_s;
    st_r.dir == TCI_DIR_NEIGHBOUR && $past(st_r.dir) == TCI_DIR_NEIGHBOUR && st_r.psc == 2'h0
      && chan1_capture_compare_enable && $rose(chan0_timer_input);
  endsequence

  sequence own_rise_s;
    st_r.dir == TCI_DIR_OWN && $past(st_r.dir) == TCI_DIR_OWN && st_r.psc == 2'h0
      && chan1_capture_compare_enable && $rose(filt_level);
  endsequence

  sequence trigger_rise_s;
    st_r.dir == TCI_DIR_TRIGGER && $past(st_r.dir) == TCI_DIR_TRIGGER && st_r.psc == 2'h0
      && chan1_capture_compare_enable && $rose(trigger_ctrl_edge_signal);
  endsequence

  sequence neighbour_fall_s;
    st_r.dir == TCI_DIR_NEIGHBOUR && $fell(chan0_timer_input);
  endsequence

  dir_write_a: assert property (cfg_write_s |=> st_r.dir == $past(hwdata[`TCI_DIR_MSB:`TCI_DIR_LSB]))
    else $error("direction write while disabled was lost");
  dir_lock_a: assert property (locked_write_s |=> $stable(st_r.dir))
    else $error("direction changed while channel enabled");
  psc_write_a: assert property (wr_now |=> st_r.psc == $past(hwdata[`TCI_PSC_MSB:`TCI_PSC_LSB]))
    else $error("prescaler field write lost");
  neighbour_event_a: assert property (neighbour_rise_s |=> chan1_capture_event)
    else $error("neighbour input edge gave no capture event");
  output_quiet_a: assert property (st_r.dir == TCI_DIR_OUTPUT ##1 st_r.dir == TCI_DIR_OUTPUT |-> !chan1_capture_event)
    else $error("capture event while channel is an output");
  reset_zero_a: assert property (!st_r.wr_seen |-> st_r.psc == 2'h0 && st_r.dir == TCI_DIR_OUTPUT && st_r.flt == 4'h0)
    else $error("config not zero after reset");
  read_back_a: assert property (addr_acc && !hwrite && addr_hit && !wr_now
    |=> hrdata[`TCI_FLT_MSB:`TCI_FLT_LSB] == st_r.flt && hrdata[`TCI_DIR_MSB:`TCI_DIR_LSB] == st_r.dir)
    else $error("read data does not show config");
  disabled_quiet_a: assert property (!chan1_capture_compare_enable ##1 !chan1_capture_compare_enable
    |-> !chan1_capture_event)
    else $error("capture event while channel disabled");

  // bus side: write pipeline, read data and decode
  write_phase_a: assert property (wr_now
    |-> $past(addr_acc) && $past(addr_hit) && $past(hwrite))
    else $error("config write without a matching address phase");

  read_data_a: assert property (rd_hit
    |=> hrdata == tci_cfg_word(st_r.psc, st_r.dir, st_r.flt))
    else $error("read data differs from the config fields");

  unmapped_read_a: assert property (addr_acc && !addr_hit
    |=> hrdata == 32'h0000_0000)
    else $error("unmapped access did not read zero");

  rdata_hold_a: assert property (!addr_acc
    |=> $stable(hrdata))
    else $error("read data moved without an address phase");

  unmapped_write_a: assert property (st_r.ph_wr && !st_r.ph_hit
    |=> $stable(st_r.psc) && $stable(st_r.dir) && $stable(st_r.flt))
    else $error("unmapped write changed the config");

  // config fields
  flt_write_a: assert property (wr_now
    |=> st_r.flt == $past(hwdata[`TCI_FLT_MSB:`TCI_FLT_LSB]))
    else $error("filter field write lost");

  locked_keep_a: assert property (locked_write_s
    |=> st_r.psc == $past(hwdata[`TCI_PSC_MSB:`TCI_PSC_LSB]) && st_r.flt == $past(hwdata[`TCI_FLT_MSB:`TCI_FLT_LSB]))
    else $error("locked write dropped more than the direction");

  psc_hold_a: assert property (!wr_now
    |=> $stable(st_r.psc))
    else $error("prescaler field moved without a write");

  flt_hold_a: assert property (!wr_now
    |=> $stable(st_r.flt))
    else $error("filter field moved without a write");

  dir_hold_a: assert property (!(wr_now && !chan1_capture_compare_enable)
    |=> $stable(st_r.dir))
    else $error("direction moved without an open write");

  dir_run_lock_a: assert property (chan1_capture_compare_enable && $past(chan1_capture_compare_enable)
    |-> $stable(st_r.dir))
    else $error("direction moved while channel ran");

  dir_change_a: assert property ($changed(st_r.dir)
    |-> $past(wr_now) && !$past(chan1_capture_compare_enable))
    else $error("direction changed outside an open write");

  // source selection
  sel_own_a: assert property (st_r.dir == TCI_DIR_OWN
    |-> sel_level == filt_level)
    else $error("own source is not the filtered input");

  sel_neighbour_a: assert property (st_r.dir == TCI_DIR_NEIGHBOUR
    |-> sel_level == chan0_timer_input)
    else $error("neighbour source not selected");

  sel_trigger_a: assert property (st_r.dir == TCI_DIR_TRIGGER
    |-> sel_level == trigger_ctrl_edge_signal)
    else $error("trigger source not selected");

  sel_output_a: assert property (st_r.dir == TCI_DIR_OUTPUT
    |-> !sel_level)
    else $error("output channel has a capture source");

  output_no_edge_a: assert property (st_r.dir == TCI_DIR_OUTPUT
    |-> !evt_raw)
    else $error("raw capture edge while channel is an output");

  // capture events
  own_event_a: assert property (own_rise_s
    |=> chan1_capture_event)
    else $error("own input edge gave no capture event");

  trigger_event_a: assert property (trigger_rise_s
    |=> chan1_capture_event)
    else $error("trigger edge gave no capture event");

  rising_only_a: assert property (neighbour_fall_s
    |=> !chan1_capture_event)
    else $error("falling edge gave a capture event");

  event_pulse_a: assert property (chan1_capture_event
    |=> !chan1_capture_event)
    else $error("capture event longer than one cycle");

  event_cause_a: assert property (chan1_capture_event
    |-> $past(chan1_capture_compare_enable) && $past(st_r.dir) != TCI_DIR_OUTPUT)
    else $error("capture event without enabled input channel");

  enable_fall_a: assert property ($fell(chan1_capture_compare_enable)
    |=> !chan1_capture_event)
    else $error("capture event after channel disable");

endmodule : tci_top

// [shared/tci_defines.svh]
`ifndef TCI_DEFINES_SVH
`define TCI_DEFINES_SVH

// register map
`define TCI_CFG_OFFSET 32'h0000_0024

// field positions inside the config word
`define TCI_PSC_LSB 18
`define TCI_PSC_MSB 19
`define TCI_DIR_LSB 16
`define TCI_DIR_MSB 17
`define TCI_FLT_LSB 0
`define TCI_FLT_MSB 3

// reset values
`define TCI_PSC_RST 2'h0
`define TCI_DIR_RST 2'h0
`define TCI_FLT_RST 4'h0
`define TCI_RDATA_RST 32'h0000_0000

`endif

// [shared/tci_pkg.sv]
package tci_pkg;

  typedef enum logic [1:0] {
    TCI_DIR_OUTPUT = 2'h0,
    TCI_DIR_OWN = 2'h1,
    TCI_DIR_NEIGHBOUR = 2'h2,
    TCI_DIR_TRIGGER = 2'h3
  } tci_dir_t;

  typedef enum logic [1:0] {
    TCI_SRC_DTS = 2'b01,
    TCI_SRC_CLKIN = 2'b10
  } tci_src_t;

  // samples that must agree before the filter output follows
  function automatic logic [3:0] tci_filter_n(input logic [3:0] code);
    logic [3:0] n;
    n = 4'h1;
    unique case (code)
      4'h0: n = 4'h1;
      4'h1: n = 4'h2;
      4'h2: n = 4'h4;
      4'h3: n = 4'h8;
      4'h4: n = 4'h6;
      4'h5: n = 4'h8;
      4'h6: n = 4'h6;
      4'h7: n = 4'h8;
      4'h8: n = 4'h6;
      4'h9: n = 4'h8;
      4'ha: n = 4'h5;
      4'hb: n = 4'h6;
      4'hc: n = 4'h8;
      4'hd: n = 4'h5;
      4'he: n = 4'h6;
      4'hf: n = 4'h8;
    endcase
    return n;
  endfunction : tci_filter_n

  // divide ratio applied to the selected sampling tick
  function automatic logic [5:0] tci_filter_div(input logic [3:0] code);
    logic [5:0] d;
    d = 6'h01;
    unique case (code)
      4'h0, 4'h1, 4'h2, 4'h3: d = 6'h01;
      4'h4, 4'h5: d = 6'h02;
      4'h6, 4'h7: d = 6'h04;
      4'h8, 4'h9: d = 6'h08;
      4'ha, 4'hb, 4'hc: d = 6'h10;
      4'hd, 4'he, 4'hf: d = 6'h20;
    endcase
    return d;
  endfunction : tci_filter_div

  function automatic tci_src_t tci_filter_src(input logic [3:0] code);
    return (code >= 4'h1 && code <= 4'h3) ? TCI_SRC_CLKIN : TCI_SRC_DTS;
  endfunction : tci_filter_src

endpackage : tci_pkg

// [tb/tci_pin_model.sv]
module tci_pin_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [2:0] lvl,
  output logic chan1_timer_input,
  output logic chan0_timer_input,
  output logic trigger_ctrl_edge_signal,
  output logic dts_en,
  output logic clkin_en
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] dcnt;
  logic [1:0] ccnt;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {chan1_timer_input, chan0_timer_input, trigger_ctrl_edge_signal} <= 3'h0;
      dcnt <= 2'h0;
      ccnt <= 2'h0;
    end else begin
      {trigger_ctrl_edge_signal, chan0_timer_input, chan1_timer_input} <= lvl;
      dcnt <= dcnt + 2'h1;
      ccnt <= (ccnt == 2'h2) ? 2'h0 : ccnt + 2'h1;
    end
  end
  // dead-time tick every 2 cycles, input clock tick every 3
  assign dts_en = dcnt[0];
  assign clkin_en = (ccnt == 2'h2);
endmodule : tci_pin_model

// [tb/timer_ch1_input_conditioning_test.sv]
module timer_ch1_input_conditioning_test;
  timeunit 1ns;
  timeprecision 1ns;
  import tci_pkg::*;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, en = 0;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 0, lvl = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic hreadyout, hresp, c1, c0, trg, dts, clkin, filt, evt;
  logic [1:0] dir;
  int n_mismatch = 0, samples_checked = 0, n_evt = 0;
  always #5 hclk = ~hclk;
  always @(posedge hclk) if (evt === 1'b1) n_evt++;
  tci_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .chan1_capture_compare_enable(en), .chan1_timer_input(c1),
    .chan0_timer_input(c0), .trigger_ctrl_edge_signal(trg), .dead_time_clock_en(dts),
    .timer_input_clock_en(clkin), .chan1_direction_select(dir), .chan1_input_filtered(filt),
    .chan1_capture_event(evt));
  tci_pin_model pins (.hclk(hclk), .hresetn(hresetn), .lvl(lvl), .chan1_timer_input(c1),
    .chan0_timer_input(c0), .trigger_ctrl_edge_signal(trg), .dts_en(dts), .clkin_en(clkin));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk("hresp", 32'h0, hresp);
  endtask : bus
  task automatic cfg(input logic [1:0] p, input logic [1:0] d, input logic [3:0] f);
    bus(1'b1, 32'h0000_0024, {12'h000, p, d, 12'h000, f});
  endtask : cfg
  task automatic wt(input int n);
    repeat (n) @(posedge hclk);
  endtask : wt
  task automatic pulse(input int s, input int w);
    lvl <= 3'h1 << (s - 1);
    wt(w);
    lvl <= 3'h0;
    wt(w);
  endtask : pulse
  task automatic arm(input logic [1:0] p, input logic [1:0] d, input logic [3:0] f);
    en <= 1'b0;
    cfg(p, d, f);
    en <= 1'b1;
    wt(2);
    n_evt = 0;
  endtask : arm
  task automatic t_reset();
    bus(1'b0, 32'h0000_0024, 32'h0);
    chk("cfg_rst", 32'h0000_0000, rd);
    chk("dir_rst", 32'h0, dir);
    bus(1'b1, 32'h0000_0028, 32'hffff_ffff);
    bus(1'b0, 32'h0000_0024, 32'h0);
    chk("cfg_unmapped", 32'h0000_0000, rd);
  endtask : t_reset
  task automatic t_lock();
    arm(2'h1, 2'h2, 4'h5);
    bus(1'b0, 32'h0000_0024, 32'h0);
    chk("cfg_open", 32'h0006_0005, rd);
    cfg(2'h3, 2'h1, 4'h7);
    bus(1'b0, 32'h0000_0024, 32'h0);
    chk("cfg_locked", 32'h000e_0007, rd);
    chk("dir_port", 32'h2, dir);
  endtask : t_lock
  task automatic t_sources();
    for (int d = 0; d < 4; d++) begin
      arm(2'h0, d[1:0], 4'h0);
      for (int s = 1; s < 4; s++) pulse(s, 6);
      chk("src_evt", (d == 0) ? 0 : 1, n_evt);
    end
  endtask : t_sources
  task automatic t_psc();
    for (int p = 0; p < 4; p++) begin
      arm(p[1:0], 2'h2, 4'h0);
      repeat (8) pulse(2, 3);
      chk("psc_evt", 8 >> p, n_evt);
    end
    arm(2'h2, 2'h2, 4'h0);
    repeat (3) pulse(2, 3);
    en <= 1'b0;
    wt(2);
    en <= 1'b1;
    wt(2);
    repeat (3) pulse(2, 3);
    chk("psc_clear", 0, n_evt);
    pulse(2, 3);
    chk("psc_after", 1, n_evt);
  endtask : t_psc
  task automatic t_flt(input logic [3:0] f, input int sh, input int lg);
    arm(2'h0, 2'h1, f);
    if (sh > 0) pulse(1, sh);
    wt(lg);
    chk("flt_glitch", 32'h0, filt);
    lvl <= 3'h1;
    wt(lg);
    chk("flt_pass", 32'h1, filt);
    lvl <= 3'h0;
    wt(lg);
    chk("flt_low", 32'h0, filt);
  endtask : t_flt
  task automatic end_of_test();
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test
  initial begin
    #300000;
    n_mismatch++;
    end_of_test();
  end
  initial begin
    wt(10);
    hresetn <= 1'b1;
    t_reset();
    t_lock();
    t_sources();
    t_psc();
    t_flt(4'h0, 0, 8);
    t_flt(4'h1, 2, 12);
    t_flt(4'h3, 12, 40);
    t_flt(4'h4, 12, 40);
    t_flt(4'h5, 16, 48);
    t_flt(4'ha, 96, 220);
    t_flt(4'hf, 256, 600);
    end_of_test();
  end
endmodule : timer_ch1_input_conditioning_test
